// [rtl/sam_pkg.sv]
// Shared constants of the serial converter control block: result layout,
// address word fields, default parameters and timing figures.
// Assumes the 25 MHz system clock and a host serial clock of 5 kHz to 3 MHz.
`default_nettype none

package sam_pkg;

  // Result word: ten magnitude bits and a sign bit
  localparam int RESULT_BITS = 11;
  localparam int MAG_BITS = 10;
  localparam int SIGN_POS = 10;

  // Address word layout and default parameters
  localparam int ADDR_BITS_DEF = 5;
  localparam int CHAN_FIELD_BITS = 3;
  localparam int SE_BIT_POS = 3;
  localparam int START_POS = 4;
  localparam logic [7:0] SOFT_PD_CODE_DEF = 8'h00;
  localparam int CHANNELS_DEF = 8;
  localparam int ACQ_CYCLES_DEF = 2;

  // Serial clock limits kept by the host
  localparam int SCLK_MIN_HZ = 5000;
  localparam int SCLK_MAX_HZ = 3000000;

  // System clock and conversion timing
  localparam int CLK_HZ = 25000000;
  localparam int CONV_MAX_NS = 5000;
  localparam int SAMPLE_RATE_MAX_HZ = 74000;
  localparam int SCLK_MIN_PERIOD_NS = (1000000000 + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
  // Longest conversion, in serial clock cycles at the fastest clock, rounded down
  localparam int CONV_SCLK_MAX = CONV_MAX_NS / SCLK_MIN_PERIOD_NS;
  // Same time in system clock cycles, rounded down
  localparam int CONV_MAX_CLK_CYC = (CONV_MAX_NS * (CLK_HZ / 1000000)) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10,
    ST_DONE = 2'b11
  } sam_state_type;

endpackage

`default_nettype wire

// [rtl/sam_sar_core.sv]
// Successive approximation register: one trial bit per serial clock, MSB first.
// Assumes the comparator decision is settled by each rising serial clock edge.
`timescale 1ns/1ns
`default_nettype none

module sam_sar_core
  import sam_pkg::*;
#(
  parameter int BITS = RESULT_BITS
)
(
  input wire logic sclk,
  input wire logic linkRst,
  input wire logic start,
  input wire logic abort,
  input wire logic compIn,
  output logic busy,
  output logic done,
  output logic [BITS-1:0] code
);

  localparam int IW = $clog2(BITS);

  logic [IW-1:0] bitIdx;

  // Trial bit kept while the held input is at or above the DAC level
  always_ff @(posedge sclk)
  begin
    if (linkRst || abort)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      bitIdx <= '0;
      code <= '0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      done <= 1'b0;
      bitIdx <= IW'(BITS - 1);
      code <= {1'b1, {(BITS-1){1'b0}}};
    end
    else if (busy)
    begin
      if (!compIn)
      begin
        code[bitIdx] <= 1'b0;
      end
      if (bitIdx == '0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        code[bitIdx - IW'(1)] <= 1'b1;
        bitIdx <= bitIdx - IW'(1);
      end
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [rtl/sam_serial_adc_mux_interface.sv]
// Serial control and readout of a 10-bit plus sign converter with input mux.
// Assumes sclk, csN and serialAddrIn come from the host in the sclk domain,
// and that the analog macro (mux, sample/hold, DAC, comparator) is clocked by sclk.
`timescale 1ns/1ns
`default_nettype none

module sam_serial_adc_mux_interface
  import sam_pkg::*;
#(
  parameter int CHANNELS = CHANNELS_DEF,
  parameter int ADDR_BITS = ADDR_BITS_DEF,
  parameter bit MSB_FIRST = 1'b1,
  parameter logic [ADDR_BITS-1:0] SOFT_PD_CODE = SOFT_PD_CODE_DEF[ADDR_BITS-1:0],
  parameter int ACQ_CYCLES = ACQ_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialAddrIn,
  input wire logic powerDownIn,
  input wire logic compIn,
  output logic serialDataOut,
  output logic serialDataOutEn,
  output logic conversionStatusOut,
  output logic conversionStatusOutEn,
  output logic [RESULT_BITS-1:0] dacCode,
  output logic trackEn,
  output logic [CHANNELS-1:0] posSel,
  output logic [CHANNELS-1:0] negSel,
  output logic negIsCom,
  output logic converterPowerDown
);

  localparam int AW = $clog2(ADDR_BITS + 1);
  localparam int QW = $clog2(ACQ_CYCLES + 1);
  localparam int OW = $clog2(RESULT_BITS + 1);
  localparam int CONV_LIMIT = CONV_SCLK_MAX;

  // Reset into the serial clock domain
  logic rstMetaL;
  logic rstSyncL;
  logic linkRst;

  // Address path
  logic [AW-1:0] addrCount;
  logic [ADDR_BITS-1:0] addrShift;
  logic [ADDR_BITS-1:0] next_addr;
  logic [ADDR_BITS-1:0] muxAddr;
  logic wordDone;
  logic startReq;
  logic softPd;

  // Conversion path
  sam_state_type state;
  logic [QW-1:0] acqCount;
  logic sarStart;
  logic sarBusy;
  logic sarDone;
  logic [RESULT_BITS-1:0] sarCode;
  logic [RESULT_BITS-1:0] result;
  logic resultValid;
  logic abortConv;

  // Output path
  logic [OW-1:0] outIdx;

  // Power control crossing
  logic pdPinMeta;
  logic pdPinSync;
  logic softPdMeta;
  logic softPdSync;
  logic pdMetaL;
  logic pdLink;

  always_ff @(posedge sclk)
  begin
    rstMetaL <= rst_n;
    rstSyncL <= rstMetaL;
  end

  assign linkRst = !rstSyncL;

  // Bit counter restarts with every frame
  always_ff @(posedge sclk or posedge csN)
  begin
    if (csN)
    begin
      addrCount <= '0;
    end
    else if (linkRst)
    begin
      addrCount <= '0;
    end
    else if (addrCount != AW'(ADDR_BITS))
    begin
      addrCount <= addrCount + AW'(1);
    end
  end

  always_comb
  begin
    if (MSB_FIRST)
    begin
      next_addr = {addrShift[ADDR_BITS-2:0], serialAddrIn};
    end
    else
    begin
      next_addr = {serialAddrIn, addrShift[ADDR_BITS-1:1]};
    end
  end

  assign wordDone = !csN && (addrCount == AW'(ADDR_BITS - 1));
  assign startReq = wordDone && next_addr[START_POS] && (next_addr != SOFT_PD_CODE) && !pdLink;

  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      addrShift <= '0;
    end
    else if (!csN && (addrCount != AW'(ADDR_BITS)))
    begin
      addrShift <= next_addr;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      muxAddr <= '0;
    end
    else if (wordDone)
    begin
      muxAddr <= next_addr;
    end
  end

  // Soft power-down set by its code, released by a start word
  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      softPd <= 1'b0;
    end
    else if (wordDone && (next_addr == SOFT_PD_CODE))
    begin
      softPd <= 1'b1;
    end
    else if (wordDone && next_addr[START_POS])
    begin
      softPd <= 1'b0;
    end
  end

  // Channel decode, one selector pair per input
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_chan
      always_ff @(posedge sclk)
      begin
        if (linkRst)
        begin
          posSel[g] <= 1'b0;
          negSel[g] <= 1'b0;
        end
        else
        begin
          posSel[g] <= (muxAddr[CHAN_FIELD_BITS-1:0] == CHAN_FIELD_BITS'(g));
          negSel[g] <= !muxAddr[SE_BIT_POS] &&
                       ((muxAddr[CHAN_FIELD_BITS-1:0] ^ CHAN_FIELD_BITS'(1)) == CHAN_FIELD_BITS'(g));
        end
      end
    end
  endgenerate

  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      negIsCom <= 1'b0;
    end
    else
    begin
      negIsCom <= muxAddr[SE_BIT_POS];
    end
  end

  assign abortConv = pdLink && ((state == ST_ACQ) || (state == ST_CONV));
  assign sarStart = (state == ST_ACQ) && (acqCount == QW'(ACQ_CYCLES - 1)) && !pdLink;

  // Acquisition then approximation, all on serial clock edges
  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      state <= ST_IDLE;
      acqCount <= '0;
    end
    else if (abortConv)
    begin
      state <= ST_IDLE;
      acqCount <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE, ST_DONE:
        begin
          if (startReq)
          begin
            state <= ST_ACQ;
            acqCount <= '0;
          end
        end
        ST_ACQ:
        begin
          acqCount <= acqCount + QW'(1);
          if (sarStart)
          begin
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (sarDone)
          begin
            state <= ST_DONE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  sam_sar_core #(
    .BITS(RESULT_BITS)
  ) u_sar (
    .sclk(sclk),
    .linkRst(linkRst),
    .start(sarStart),
    .abort(abortConv),
    .compIn(compIn),
    .busy(sarBusy),
    .done(sarDone),
    .code(sarCode)
  );

  // Offset binary from the approximation becomes two's complement
  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      result <= '0;
      resultValid <= 1'b0;
    end
    else if ((startReq && ((state == ST_IDLE) || (state == ST_DONE))) || abortConv)
    begin
      resultValid <= 1'b0;
    end
    else if (sarDone && (state == ST_CONV))
    begin
      result <= {~sarCode[SIGN_POS], sarCode[MAG_BITS-1:0]};
      resultValid <= 1'b1;
    end
  end

  // Track during acquisition, hold from the first trial onward
  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      trackEn <= 1'b0;
    end
    else
    begin
      trackEn <= (state == ST_ACQ) && !sarStart && !pdLink;
    end
  end

  // The comparator must see the trial that the next edge decides on
  assign dacCode = sarCode;

  // Output bit index restarts with every frame
  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      outIdx <= '0;
    end
    else if (linkRst || !resultValid)
    begin
      outIdx <= '0;
    end
    else if (outIdx != OW'(RESULT_BITS))
    begin
      outIdx <= outIdx + OW'(1);
    end
  end

  always_ff @(negedge sclk)
  begin
    if (linkRst)
    begin
      serialDataOut <= 1'b0;
    end
    else if (!csN && resultValid)
    begin
      if (outIdx < OW'(RESULT_BITS))
      begin
        serialDataOut <= result[outIdx];
      end
      else
      begin
        serialDataOut <= 1'b0;
      end
    end
  end

  assign serialDataOutEn = !csN && resultValid;
  assign conversionStatusOutEn = !csN;
  assign conversionStatusOut = (state == ST_ACQ) || (state == ST_CONV);

  // Power control in the system clock domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pdPinMeta <= 1'b0;
      pdPinSync <= 1'b0;
      softPdMeta <= 1'b0;
      softPdSync <= 1'b0;
      converterPowerDown <= 1'b0;
    end
    else
    begin
      pdPinMeta <= powerDownIn;
      pdPinSync <= pdPinMeta;
      softPdMeta <= softPd;
      softPdSync <= softPdMeta;
      converterPowerDown <= pdPinSync || softPdSync;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (linkRst)
    begin
      pdMetaL <= 1'b0;
      pdLink <= 1'b0;
    end
    else
    begin
      pdMetaL <= converterPowerDown;
      pdLink <= pdMetaL;
    end
  end

  // Cycles spent from acquisition start, for the budget check
  logic [4:0] convCycles;
  always_ff @(posedge sclk)
  begin
    if (linkRst || !conversionStatusOut)
    begin
      convCycles <= '0;
    end
    else if (convCycles != 5'h1f)
    begin
      convCycles <= convCycles + 5'h01;
    end
  end

  AST_START_STATUS: assert property (@(posedge sclk) disable iff (linkRst)
    startReq |=> conversionStatusOut && !resultValid)
    else $error("status not raised after address word");

  AST_CONV_LENGTH: assert property (@(posedge sclk) disable iff (linkRst || pdLink)
    sarStart |-> ##13 (state == ST_DONE) && resultValid)
    else $error("conversion did not end after eleven trials");

  AST_CONV_BUDGET: assert property (@(posedge sclk) disable iff (linkRst)
    conversionStatusOut |-> (convCycles <= CONV_LIMIT))
    else $error("conversion exceeds time budget");

  AST_DO_FLOAT: assert property (@(posedge sclk) disable iff (linkRst)
    (state == ST_ACQ) |-> !serialDataOutEn)
    else $error("serial output driven before completion");

  AST_DO_DRIVE: assert property (@(posedge sclk) disable iff (linkRst)
    (state == ST_DONE) && !csN |-> serialDataOutEn)
    else $error("serial output not driven after completion");

  AST_STATUS_LOW: assert property (@(posedge sclk) disable iff (linkRst)
    sarDone && (state == ST_CONV) |=> !conversionStatusOut)
    else $error("status high after result ready");

  AST_ADDR_IGNORE: assert property (@(posedge sclk) disable iff (linkRst)
    csN |=> $stable(addrShift))
    else $error("address shifted with select high");

  AST_ADDR_SHIFT: assert property (@(posedge sclk) disable iff (linkRst || !MSB_FIRST)
    !csN && (addrCount != AW'(ADDR_BITS)) |=> addrShift[0] == $past(serialAddrIn))
    else $error("address bit not captured");

  AST_MUX_LOAD: assert property (@(posedge sclk) disable iff (linkRst)
    wordDone |=> ##1 posSel[muxAddr[CHAN_FIELD_BITS-1:0] % CHANNELS])
    else $error("mux selection does not follow address");

  AST_HOLD: assert property (@(posedge sclk) disable iff (linkRst)
    (state == ST_CONV) |=> !trackEn)
    else $error("input tracking during conversion");

  AST_SOFT_PD: assert property (@(posedge sclk) disable iff (linkRst)
    wordDone && (next_addr == SOFT_PD_CODE) |=> softPd && !conversionStatusOut)
    else $error("soft power-down code not taken");

  AST_PD_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    pdPinSync |=> converterPowerDown)
    else $error("power-down pin not obeyed");

  AST_DO_LSB: assert property (@(negedge sclk) disable iff (linkRst)
    !csN && resultValid && (outIdx == '0) |=> serialDataOut == result[0])
    else $error("first output bit is not the lsb");

  COV_CONV_DONE: cover property (@(posedge sclk) disable iff (linkRst)
    sarDone && (state == ST_CONV));
  COV_SIGN_OUT: cover property (@(negedge sclk) disable iff (linkRst)
    !csN && resultValid && (outIdx == OW'(SIGN_POS)));
  COV_SOFT_PD: cover property (@(posedge sclk) disable iff (linkRst)
    wordDone && (next_addr == SOFT_PD_CODE));
  COV_PD_ABORT: cover property (@(posedge sclk) disable iff (linkRst)
    abortConv);

endmodule

`default_nettype wire

// [bench/sam_host_model.sv]
// Host side of the serial link: makes the link clock, select and address bits,
// and records what the converter shows after every falling link clock edge within a frame.
// Assumes the converter captures on rising and shifts on falling link clock edges.
`timescale 1ns/1ns
`default_nettype none

module sam_host_model
(
  output logic sclk,
  output logic csN,
  output logic serialAddrIn,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  input wire logic conversionStatusOut,
  input wire logic conversionStatusOutEn
);
  logic dout [0:63];
  logic stat [0:63];

  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    serialAddrIn = 1'b0;
  end

  // Select high; the data line keeps changing so a stray capture shows up
  task automatic idle(input int n);
    for (int i = 0; i < n; i++)
    begin
      serialAddrIn = ~serialAddrIn;
      #2 sclk = 1'b1;
      #3 sclk = 1'b0;
      #1;
    end
  endtask

  // Address word msb first, then a wandering data line; clock stands still outside
  task automatic frame(input logic [4:0] word, input int n);
    csN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serialAddrIn = (i < 5) ? word[4 - i] : ~serialAddrIn;
      #2 sclk = 1'b1;
      #3 sclk = 1'b0;
      #1 dout[i] = serialDataOutEn ? serialDataOut : 1'bz;
      stat[i] = conversionStatusOutEn ? conversionStatusOut : 1'bz;
    end
    csN = 1'b1;
    #6;
  endtask
endmodule

`default_nettype wire

// [bench/sam_serial_adc_mux_interface_test.sv]
// Self-checking bench of the converter control block with a host model and a
// comparator model that holds the input while tracking is off.
// Assumes the default address layout and acquisition length of the design.
`timescale 1ns/1ns
`default_nettype none

module sam_serial_adc_mux_interface_test;
  import sam_pkg::*;

  localparam logic [4:0] PD_WORD = 5'h07;

  logic clk;
  logic rst_n;
  logic powerDownIn;
  wire logic compIn;
  wire logic sclk;
  wire logic csN;
  wire logic serialAddrIn;
  logic serialDataOut;
  logic serialDataOutEn;
  logic conversionStatusOut;
  logic conversionStatusOutEn;
  logic [RESULT_BITS-1:0] dacCode;
  logic trackEn;
  logic [7:0] posSel;
  logic [7:0] negSel;
  logic negIsCom;
  logic converterPowerDown;
  logic [10:0] analog;
  logic [10:0] held;
  int badCount;
  int comparisons;

  sam_serial_adc_mux_interface #(
    .SOFT_PD_CODE(PD_WORD)
  ) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .csN(csN),
    .serialAddrIn(serialAddrIn),
    .powerDownIn(powerDownIn),
    .compIn(compIn),
    .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn),
    .conversionStatusOut(conversionStatusOut),
    .conversionStatusOutEn(conversionStatusOutEn),
    .dacCode(dacCode),
    .trackEn(trackEn),
    .posSel(posSel),
    .negSel(negSel),
    .negIsCom(negIsCom),
    .converterPowerDown(converterPowerDown)
  );

  sam_host_model host_u (
    .sclk(sclk),
    .csN(csN),
    .serialAddrIn(serialAddrIn),
    .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn),
    .conversionStatusOut(conversionStatusOut),
    .conversionStatusOutEn(conversionStatusOutEn)
  );

  // Sample and hold: follows the input only while tracking
  always @(trackEn or analog)
    if (trackEn === 1'b1)
      held = analog;
  assign compIn = (held >= dacCode);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    if (badCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      badCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic waitTrack(input logic level);
    int i;
    for (i = 0; i < 500 && trackEn !== level; i++)
      #1;
    if (i == 500)
    begin
      badCount++;
      summarize();
    end
  endtask

  task automatic firstFrame();
    host_u.frame(5'h00, 12);
    for (int i = 0; i < 12; i++)
      check("output before any result", host_u.dout[i], 1'bz);
  endtask

  task automatic readResult(input logic [10:0] expRes);
    host_u.frame(5'h00, 13);
    for (int i = 0; i < 11; i++)
      check("result bit", host_u.dout[i], expRes[i]);
    check("bit after sign", host_u.dout[11], 1'b0);
  endtask

  task automatic convert(input logic [2:0] ch, input logic se, input logic [10:0] v);
    int busyCyc;
    busyCyc = 0;
    analog = v;
    fork
      host_u.frame({1'b1, se, ch}, 40);
      begin
        waitTrack(1'b1);
        waitTrack(1'b0);
        analog = ~v;
      end
    join
    for (int i = 0; i < 40; i++)
      busyCyc += (host_u.stat[i] === 1'b1);
    check("status before word end", host_u.stat[3], 1'b0);
    check("status at start", host_u.stat[4], 1'b1);
    check("status after result", host_u.stat[39], 1'b0);
    check("output while busy", host_u.dout[6], 1'bz);
    check("busy within budget", busyCyc >= 11 && busyCyc <= CONV_SCLK_MAX, 1'b1);
    check("positive select", posSel, 8'h01 << ch);
    if (se)
      check("return to common", negIsCom, 1'b1);
    else
      check("negative select", negSel, 8'h01 << (ch ^ 3'd1));
    host_u.idle(10);
    check("select after idle clocks", posSel, 8'h01 << ch);
    check("status enable", conversionStatusOutEn, 1'b0);
    check("output enable", serialDataOutEn, 1'b0);
    repeat (2) readResult({~v[10], v[9:0]});
  endtask

  task automatic pinPowerDown();
    @(negedge clk) powerDownIn = 1'b1;
    waitClk(5);
    check("pin power down", converterPowerDown, 1'b1);
    host_u.idle(4);
    host_u.frame(5'h1a, 30);
    for (int i = 0; i < 30; i++)
      check("status while down", host_u.stat[i], 1'b0);
    @(negedge clk) powerDownIn = 1'b0;
    waitClk(5);
    check("pin power up", converterPowerDown, 1'b0);
    host_u.idle(4);
  endtask

  task automatic softPowerDown();
    host_u.frame(PD_WORD, 8);
    waitClk(5);
    check("soft power down", converterPowerDown, 1'b1);
    host_u.frame(5'h1b, 40);
    waitClk(5);
    check("soft power released", converterPowerDown, 1'b0);
  endtask

  initial
  begin
    #200000;
    badCount++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    powerDownIn = 1'b0;
    analog = 11'h000;
    held = 11'h000;
    badCount = 0;
    comparisons = 0;
    fork
      waitClk(20);
      host_u.idle(130);
    join
    rst_n = 1'b1;
    host_u.idle(4);
    firstFrame();
    for (int c = 0; c < 8; c++)
      convert(3'(c), c[0], 11'h7ff - 11'(c * 291));
    pinPowerDown();
    softPowerDown();
    convert(3'd3, 1'b0, 11'h000);
    summarize();
  end
endmodule

`default_nettype wire
